// >>> rtl/wwd_pkg.sv
package wwd_pkg;

	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned CNT_W  = 24;

	// register byte offsets
	localparam logic [7:0] OFF_MODE    = 8'h00;
	localparam logic [7:0] OFF_TIMEOUT = 8'h04;
	localparam logic [7:0] OFF_FEED    = 8'h08;
	localparam logic [7:0] OFF_COUNT   = 8'h0c;
	localparam logic [7:0] OFF_WARN    = 8'h10;
	localparam logic [7:0] OFF_WINDOW  = 8'h14;
	localparam logic [7:0] OFF_STATUS  = 8'h18;
	localparam logic [7:0] OFF_MASK    = 8'h1c;

	// mode register fields
	localparam int unsigned MODE_EN_BIT   = 0;
	localparam int unsigned MODE_IRQ_BIT  = 1;
	localparam int unsigned MODE_WIN_BIT  = 2;

	// status and mask register fields
	localparam int unsigned ST_W           = 4;
	localparam int unsigned ST_TIMEOUT_BIT = 0;
	localparam int unsigned ST_WARN_BIT    = 1;
	localparam int unsigned ST_FAULT_BIT   = 2;
	localparam int unsigned ST_WDRST_BIT   = 3;

	// feed keys, written back to back
	localparam logic [7:0] FEED_KEY_1 = 8'haa;
	localparam logic [7:0] FEED_KEY_2 = 8'h55;

	// reset values
	localparam logic [CNT_W-1:0] TIMEOUT_RST = 24'hffffff;
	localparam logic [CNT_W-1:0] WARN_RST    = 24'h000000;
	localparam logic [CNT_W-1:0] WINDOW_RST  = 24'hffffff;
	localparam logic [ST_W-1:0]  MASK_RST    = 4'h0;

	// fixed internal prescaler: one tick every PRESCALE core clocks
	localparam int unsigned PRESCALE   = 4;
	localparam int unsigned PRESCALE_W = 2;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              we;
		logic              re;
	} wwd_bus_t;

	typedef struct packed {
		logic enable;
		logic irq_mode;
		logic win_en;
	} wwd_mode_t;

	typedef enum logic [1:0] {
		FEED_IDLE  = 2'b01,
		FEED_ARMED = 2'b10
	} wwd_feed_state_t;

endpackage

// >>> rtl/wwd_prescaler.sv
`timescale 1ns/1ns
module wwd_prescaler (
	input  wire logic i_core_clk,
	input  wire logic i_rstn,
	input  wire logic i_run,
	output logic      o_tick
);
	logic [wwd_pkg::PRESCALE_W-1:0] div_reg;

	always_ff @(posedge i_core_clk) begin
		if (!i_rstn || !i_run) begin
			div_reg <= '0;
		end else begin
			div_reg <= div_reg + 1'b1;
		end
	end

	// counter width fits the prescale exactly, so wrap marks the tick
	assign o_tick = i_run && (div_reg == wwd_pkg::PRESCALE_W'(wwd_pkg::PRESCALE - 1));
endmodule // wwd_prescaler

// >>> rtl/wwd_feed_check.sv
`timescale 1ns/1ns
module wwd_feed_check (
	input  wire logic             i_core_clk,
	input  wire logic             i_rstn,
	input  wire wwd_pkg::wwd_bus_t i_bus,
	output logic                  o_feed_ok,
	output logic                  o_feed_bad
);
	wwd_pkg::wwd_feed_state_t state_reg;
	wwd_pkg::wwd_feed_state_t state_next;
	logic                     feed_wr;
	logic                     any_acc;

	assign feed_wr = i_bus.we && (i_bus.addr == wwd_pkg::OFF_FEED);
	assign any_acc = i_bus.we || i_bus.re;

	always_comb begin
		state_next = state_reg;
		o_feed_ok  = 1'b0;
		o_feed_bad = 1'b0;
		case (state_reg)
			wwd_pkg::FEED_IDLE: begin
				if (feed_wr) begin
					if (i_bus.wdata[7:0] == wwd_pkg::FEED_KEY_1) begin
						state_next = wwd_pkg::FEED_ARMED;
					end else begin
						o_feed_bad = 1'b1;
					end
				end
			end
			wwd_pkg::FEED_ARMED: begin
				// the very next access must be the second key
				if (any_acc) begin
					state_next = wwd_pkg::FEED_IDLE;
					if (feed_wr && i_bus.wdata[7:0] == wwd_pkg::FEED_KEY_2) begin
						o_feed_ok = 1'b1;
					end else begin
						o_feed_bad = 1'b1;
					end
				end
			end
			default: begin
				state_next = wwd_pkg::FEED_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			state_reg <= wwd_pkg::FEED_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end
endmodule // wwd_feed_check

// >>> rtl/wwd_top.sv
`timescale 1ns/1ns
module wwd_top (
	input  wire logic        i_core_clk,
	input  wire logic        i_rstn,
	input  wire logic [7:0]  i_addr,
	input  wire logic [31:0] i_wdata,
	input  wire logic        i_we,
	input  wire logic        i_re,
	output logic      [31:0] o_rdata,
	output logic             o_irq,
	output logic             o_chip_reset_req
);
	localparam int unsigned CW = wwd_pkg::CNT_W;
	localparam int unsigned SW = wwd_pkg::ST_W;

	wwd_pkg::wwd_bus_t  bus;
	wwd_pkg::wwd_mode_t mode_reg;
	logic [CW-1:0]      timeout_reg;
	logic [CW-1:0]      warn_reg;
	logic [CW-1:0]      window_reg;
	logic [CW-1:0]      count_reg;
	logic [SW-1:0]      status_reg;
	logic [SW-1:0]      mask_reg;
	logic [31:0]        rdata_reg;
	logic               rstreq_reg;

	logic tick;
	logic feed_ok;
	logic feed_bad;
	logic win_early;
	logic fault;
	logic expire;
	logic warn_hit;
	logic bite;
	logic reload;
	logic [SW-1:0] ev;

	assign bus.addr  = i_addr;
	assign bus.wdata = i_wdata;
	assign bus.we    = i_we;
	assign bus.re    = i_re;

	wwd_prescaler u_presc (
		.i_core_clk (i_core_clk),
		.i_rstn     (i_rstn),
		.i_run      (mode_reg.enable),
		.o_tick     (tick)
	);

	wwd_feed_check u_feed (
		.i_core_clk (i_core_clk),
		.i_rstn     (i_rstn),
		.i_bus      (bus),
		.o_feed_ok  (feed_ok),
		.o_feed_bad (feed_bad)
	);

	// window opens once the count has fallen to the window value
	assign win_early = mode_reg.win_en && (count_reg > window_reg);
	assign fault     = mode_reg.enable && (feed_bad || (feed_ok && win_early));
	assign reload    = feed_ok && !win_early;
	assign expire    = mode_reg.enable && tick && (count_reg == '0) && !reload;
	assign warn_hit  = mode_reg.enable && tick && (count_reg == warn_reg);
	// time-out and fault share one response: reset, or interrupt in irq mode
	assign bite      = expire || fault;

	// mode: enable can only be set by software
	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			mode_reg <= '0;
		end else begin
			if (i_we && i_addr == wwd_pkg::OFF_MODE) begin
				mode_reg.irq_mode <= i_wdata[wwd_pkg::MODE_IRQ_BIT];
				mode_reg.win_en   <= i_wdata[wwd_pkg::MODE_WIN_BIT];
				if (i_wdata[wwd_pkg::MODE_EN_BIT]) begin
					mode_reg.enable <= 1'b1;
				end
			end
			if (bite) begin
				mode_reg.enable <= 1'b0;
			end
		end
	end

	// limits and interrupt mask
	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			timeout_reg <= wwd_pkg::TIMEOUT_RST;
			warn_reg    <= wwd_pkg::WARN_RST;
			window_reg  <= wwd_pkg::WINDOW_RST;
			mask_reg    <= wwd_pkg::MASK_RST;
		end else if (i_we) begin
			case (i_addr)
				wwd_pkg::OFF_TIMEOUT: timeout_reg <= i_wdata[CW-1:0];
				wwd_pkg::OFF_WARN:    warn_reg    <= i_wdata[CW-1:0];
				wwd_pkg::OFF_WINDOW:  window_reg  <= i_wdata[CW-1:0];
				wwd_pkg::OFF_MASK:    mask_reg    <= i_wdata[SW-1:0];
				default: begin
				end
			endcase
		end
	end

	// down counter; parked at the reload value while disabled
	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			count_reg <= wwd_pkg::TIMEOUT_RST;
		end else if (!mode_reg.enable || reload || bite) begin
			count_reg <= timeout_reg;
		end else if (tick && count_reg != '0) begin
			count_reg <= count_reg - 1'b1;
		end
	end

	// events into sticky status
	always_comb begin
		ev = '0;
		ev[wwd_pkg::ST_TIMEOUT_BIT] = expire;
		ev[wwd_pkg::ST_WARN_BIT]    = warn_hit;
		ev[wwd_pkg::ST_FAULT_BIT]   = fault;
		ev[wwd_pkg::ST_WDRST_BIT]   = bite && !mode_reg.irq_mode;
	end

	// write one clears; an event in the same cycle wins
	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			status_reg <= '0;
		end else begin
			if (i_we && i_addr == wwd_pkg::OFF_STATUS) begin
				status_reg <= (status_reg & ~i_wdata[SW-1:0]) | ev;
			end else begin
				status_reg <= status_reg | ev;
			end
		end
	end

	// one-cycle chip reset request, only when not in interrupt mode
	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			rstreq_reg <= 1'b0;
		end else begin
			rstreq_reg <= bite && !mode_reg.irq_mode;
		end
	end

	// read port, data one cycle after the strobe, zero otherwise
	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			rdata_reg <= '0;
		end else if (i_re) begin
			case (i_addr)
				wwd_pkg::OFF_MODE: begin
					rdata_reg <= {29'h0, mode_reg.win_en, mode_reg.irq_mode,
						mode_reg.enable};
				end
				wwd_pkg::OFF_TIMEOUT: rdata_reg <= {8'h0, timeout_reg};
				wwd_pkg::OFF_COUNT:   rdata_reg <= {8'h0, count_reg};
				wwd_pkg::OFF_WARN:    rdata_reg <= {8'h0, warn_reg};
				wwd_pkg::OFF_WINDOW:  rdata_reg <= {8'h0, window_reg};
				wwd_pkg::OFF_STATUS:  rdata_reg <= {28'h0, status_reg};
				wwd_pkg::OFF_MASK:    rdata_reg <= {28'h0, mask_reg};
				default:              rdata_reg <= '0;
			endcase
		end else begin
			rdata_reg <= '0;
		end
	end

	assign o_rdata          = rdata_reg;
	assign o_chip_reset_req = rstreq_reg;
	assign o_irq            = |(status_reg & mask_reg);
endmodule // wwd_top

// >>> dv/wwd_asserts.sv
`timescale 1ns/1ns
module wwd_asserts (
	input  wire logic        i_core_clk,
	input  wire logic        i_rstn,
	input  wire logic [7:0]  i_addr,
	input  wire logic [31:0] i_wdata,
	input  wire logic        i_we,
	input  wire logic        i_re,
	input  wire logic [31:0] o_rdata,
	input  wire logic        o_irq,
	input  wire logic        o_chip_reset_req
);
	logic [3:0] m_reg;
	logic       en_reg;
	logic       irqm_reg;
	logic       wd_reg;
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_rstn);
	// shadow of mask and mode writes; enable shadow never clears, so it is conservative
	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			m_reg    <= 4'h0;
			en_reg   <= 1'b0;
			irqm_reg <= 1'b0;
		end else if (i_we && i_addr == 8'h1c) begin
			m_reg <= i_wdata[3:0];
		end else if (i_we && i_addr == 8'h00) begin
			en_reg   <= en_reg | i_wdata[0];
			irqm_reg <= i_wdata[1];
		end
	end
	always_ff @(posedge i_core_clk) begin
		if (!i_rstn || (i_we && i_addr == 8'h18 && i_wdata[3]))
			wd_reg <= 1'b0;
		else if (o_chip_reset_req)
			wd_reg <= 1'b1;
	end
	rdata_idle_a: assert property (!i_re |=> o_rdata == 32'h0)
		else $error("read data not zero outside a read");
	unmapped_zero_a: assert property (i_re && i_addr > 8'h1c |=> o_rdata == 32'h0)
		else $error("unmapped read not zero");
	count_width_a: assert property (i_re && i_addr == 8'h0c |=> o_rdata[31:24] == 8'h0)
		else $error("count wider than 24 bits");
	req_pulse_a: assert property (o_chip_reset_req |=> !o_chip_reset_req)
		else $error("reset request longer than one cycle");
	no_req_a: assert property (!en_reg || irqm_reg |-> !o_chip_reset_req)
		else $error("reset request while disabled or in interrupt mode");
	irq_masked_a: assert property (m_reg == 4'h0 |-> !o_irq)
		else $error("interrupt with all sources masked");
	wdflag_irq_a: assert property (o_chip_reset_req && m_reg[3] && !i_we |=> o_irq)
		else $error("watchdog reset flag did not raise interrupt");
	wdflag_read_a: assert property (wd_reg && i_re && i_addr == 8'h18 |=> o_rdata[3])
		else $error("watchdog reset flag not readable");
endmodule // wwd_asserts
bind wwd_top wwd_asserts u_chk (.i_core_clk, .i_rstn, .i_addr, .i_wdata, .i_we, .i_re,
	.o_rdata, .o_irq, .o_chip_reset_req);

// >>> dv/testbench.sv
`timescale 1ns/1ns
module testbench;
	logic        clk;
	logic        rstn;
	logic        we;
	logic        re;
	logic        rv;
	logic        irq;
	logic        req;
	logic [7:0]  addr;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic [31:0] seed;
	logic [31:0] q[$];
	logic [31:0] rst_v [9] = '{32'h0, 32'hffffff, 32'h0, 32'hffffff, 32'h0,
		32'hffffff, 32'h0, 32'h0, 32'h0};
	int          error_cnt;
	int          checks;
	int          n;
	int          k;
	wwd_top uut (.i_core_clk(clk), .i_rstn(rstn), .i_addr(addr), .i_wdata(wdata),
		.i_we(we), .i_re(re), .o_rdata(rdata), .o_irq(irq), .o_chip_reset_req(req));
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		return s ^ (s << 5);
	endfunction
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// one idle cycle after each access so a strobe is never re-driven in its own step
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		we    <= 1'b1;
		@(posedge clk);
		we <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		q.push_back(e);
		@(posedge clk);
		addr <= a;
		re   <= 1'b1;
		@(posedge clk);
		re <= 1'b0;
	endtask
	task automatic feed;
		wr(8'h08, 32'haa);
		wr(8'h08, 32'h55);
	endtask
	task automatic wt(input int lim);
		n = 0;
		// look once before the next edge: a fault bite pulse lasts one cycle only
		#1;
		while (req !== 1'b1 && n < lim) begin
			@(posedge clk);
			#1;
			n++;
		end
	endtask
	task automatic summarize;
		$display("checks=%0d error_cnt=%0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) rv <= re;
	always @(negedge clk) if (rv) chk(rdata, q.pop_front());
	initial begin
		#20000;
		error_cnt++;
		summarize();
	end
	initial begin
		rstn  = 1'b0;
		we    = 1'b0;
		re    = 1'b0;
		addr  = 8'h0;
		wdata = 32'h0;
		seed  = 32'h2be7;
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		for (k = 0; k < 9; k++)
			if (k != 2) rd(8'(k * 4), rst_v[k]);
		for (k = 0; k < 3; k++) begin
			seed = xs(seed);
			wr(8'h04, seed);
			wr(8'h0c, ~seed);
			wr(8'h1c, seed);
			rd(8'h0c, {8'h0, seed[23:0]});
			rd(8'h04, {8'h0, seed[23:0]});
			rd(8'h1c, {28'h0, seed[3:0]});
		end
		wr(8'h04, 32'h6);
		wr(8'h10, 32'h2);
		wr(8'h1c, 32'h2);
		wr(8'h00, 32'h1);
		wr(8'h00, 32'h0);
		rd(8'h00, 32'h1);
		feed();
		@(negedge clk);
		chk(irq, 1'b0);
		wt(40);
		chk(n >= 24 && n <= 30, 1'b1);
		chk(irq, 1'b1);
		rd(8'h18, 32'hb);
		rd(8'h00, 32'h0);
		wr(8'h18, 32'hf);
		rd(8'h18, 32'h0);
		for (k = 0; k < 2; k++) begin
			wr(8'h04, 32'h28);
			wr(8'h1c, 32'h8);
			wr(8'h00, 32'h1);
			wr(8'h08, k ? 32'h12 : 32'haa);
			if (k == 0) rd(8'h04, 32'h28);
			wt(10);
			chk(req, 1'b1);
			rd(8'h18, 32'hc);
			wr(8'h18, 32'hf);
		end
		wr(8'h1c, 32'h4);
		wr(8'h00, 32'h3);
		wr(8'h08, 32'h55);
		wt(10);
		chk(req, 1'b0);
		chk(irq, 1'b1);
		rd(8'h00, 32'h2);
		wr(8'h18, 32'hf);
		@(negedge clk);
		chk(irq, 1'b0);
		wr(8'h14, 32'ha);
		wr(8'h00, 32'h5);
		feed();
		wt(10);
		chk(req, 1'b1);
		rd(8'h18, 32'hc);
		// window open: count has fallen to the window value, so the feed reloads
		wr(8'h18, 32'hf);
		wr(8'h04, 32'h8);
		wr(8'h14, 32'h4);
		wr(8'h00, 32'h5);
		repeat (20) @(posedge clk);
		feed();
		wt(10);
		chk(req, 1'b0);
		rd(8'h18, 32'h0);
		repeat (3) @(posedge clk);
		summarize();
	end
endmodule // testbench
